/* File: pwm_gen_map.svh */
// Purpose: Register offsets, field positions and reset values of the PWM generators.
// Assumes: Byte addresses on a 32-bit Wishbone bus; one aligned word per register.
// Notes: Definitions only.
`ifndef PWM_GEN_MAP_SVH
`define PWM_GEN_MAP_SVH

// Generator g occupies the window g*0x20; register index is address bits 4:2.
`define PWM_GEN_COUNT 3
`define PWM_REG_CONTROL 3'h0
`define PWM_REG_SCALER 3'h1
`define PWM_REG_DUTY_HIGH 3'h2
`define PWM_REG_DUTY_LOW 3'h3
`define PWM_REG_BOUND_HIGH 3'h4
`define PWM_REG_BOUND_LOW 3'h5
`define PWM_GLOBAL_WINDOW 2'h3
`define PWM_REG_IRQ_STATUS 3'h0
`define PWM_REG_IRQ_MASK 3'h1

`define PWM_CTRL_ENABLE 7
`define PWM_CTRL_INVERT 6
`define PWM_CTRL_FAST_RC 4
`define PWM_CTRL_PIN_MSB 1
`define PWM_CTRL_PIN_LSB 0
`define PWM_SCL_IRQ_AT_DUTY 7
`define PWM_SCL_PRE_MSB 6
`define PWM_SCL_PRE_LSB 5
`define PWM_SCL_DIV_MSB 4
`define PWM_DUTY_HALF_BIT 5

`define PWM_PIN_SLOTS 4
`define PWM_PINS_FIRST 3'h3
`define PWM_PINS_SECOND 3'h3
`define PWM_PINS_THIRD 3'h4

`define PWM_REG_RESET 8'h00

`endif

/* File: pwm_gen_pkg.sv */
// Purpose: Shared types of the PWM generator block.
// Assumes: Nothing beyond the map header.
// Notes: Types only.
`default_nettype none
package pwm_gen_pkg;
	typedef logic [7:0] reg8_t;
	typedef logic [11:0] div_t;
	typedef logic [9:0] bound_t;
endpackage
`default_nettype wire

/* File: pwm_gen_11bit.sv */
// Purpose: Three 11-bit PWM generators behind a classic Wishbone slave.
// Assumes: FAST_RC_TICK_IN is a one-cycle enable synchronous to CLOCK_IN.
// Notes: Half-step duty is exact only when the total division is even.
// Notes: Status bits are sticky until read or written with a one; one read clears them all.
// Function
// RULE1: three identical independent generators, own pins
// RULE2: counter clock from fast RC or system
// RULE3: pin select routes to exactly one pin; the code drives no pin for a select beyond the pins the generator owns
// RULE4: selected pin driven regardless of direction
// RULE5: period bound from bound high/low bits
// RULE6: duty bound plus half-step bit
// RULE7: frequency is source over P, K+1, bound+1
// RULE8: scaler bits 6:5 give 1,4,16,64
// RULE9: scaler bits 4:0 divide by value plus one
// RULE10: high fraction includes half-step and one half
// RULE11: build option lets comparator gate output
// RULE12: comparator high holds output off
// RULE13: control holds enable, invert, pin, source
// RULE14: scaler bit moves interrupt to duty match
// RULE15: software writes bounds before enabling
// RULE16: software builds complementary pairs with dead time
// RULE17: per-generator interrupt flag, software clears it
// RULE18: counter wraps at bound, high until duty
// RULE19: disabled: counter zero, output inactive, pin released
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`include "pwm_gen_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_gen_11bit #(
	parameter logic [2:0] GATE_BY_COMPARATOR = 3'h0,
	parameter int PIN_SLOTS = `PWM_PIN_SLOTS
) (
	input wire logic CLOCK_IN,
	input wire logic SYS_RST_IN,
	input wire logic FAST_RC_TICK_IN,
	input wire logic COMP_RESULT_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	output logic IRQ_OUT,
	output logic [11:0] PWM_PIN_OUT,
	output logic [11:0] PWM_PIN_OE_OUT
);

	localparam int NG = `PWM_GEN_COUNT;

	if (PIN_SLOTS != `PWM_PIN_SLOTS) begin : g_bad_slots
		$error("PIN_SLOTS must be 4");
	end

	if (NG * PIN_SLOTS != 12) begin : g_bad_pins
		$error("pin vector width does not match generator count");
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// The widest division, 64 times 32, is 2048 and fits the twelve-bit type.
	// A wider scaler field would need a wider division type as well.
	// RULE8 prescale codes
	// RULE9 extra divide by K+1
	function automatic pwm_gen_pkg::div_t div_of(input pwm_gen_pkg::reg8_t s);
		pwm_gen_pkg::div_t k;
		k = {7'h00, s[`PWM_SCL_DIV_MSB:0]} + 12'h001;
		return k << {s[`PWM_SCL_PRE_MSB:`PWM_SCL_PRE_LSB], 1'b0};
	endfunction

	function automatic logic [2:0] pins_of(input int g);
		return (g == 0) ? `PWM_PINS_FIRST : (g == 1) ? `PWM_PINS_SECOND : `PWM_PINS_THIRD;
	endfunction

	for (genvar g = 0; g < NG; g++) begin : g_pin_check
		if (pins_of(g) > PIN_SLOTS) begin : g_bad
			$error("generator owns more pins than slots");
		end
	end

	// Upper ten bits of a bound: whole high byte, top two bits of the low byte.
	function automatic pwm_gen_pkg::bound_t bound_of(input pwm_gen_pkg::reg8_t hi,
			input pwm_gen_pkg::reg8_t lo);
		return {hi, lo[7:6]};
	endfunction

	// Registers read back in the low byte of the bus word; the rest reads zero.
	function automatic logic [31:0] word_of(input pwm_gen_pkg::reg8_t v);
		return {24'h00_0000, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file and Wishbone slave.
	// Each generator owns a window of eight word slots; window 3 holds the
	// shared interrupt status and mask words. Only the low byte of a write
	// lands, and only when its byte select is set. Addresses with bit 7 set
	// decode to nothing: they are answered with zero data so that a stray
	// access never stalls the bus.

	// One copy of every register per generator, indexed by generator.
	pwm_gen_pkg::reg8_t ctrl_q [NG];
	pwm_gen_pkg::reg8_t ctrl_d [NG];
	pwm_gen_pkg::reg8_t scl_q [NG];
	pwm_gen_pkg::reg8_t scl_d [NG];
	pwm_gen_pkg::reg8_t dhi_q [NG];
	pwm_gen_pkg::reg8_t dhi_d [NG];
	pwm_gen_pkg::reg8_t dlo_q [NG];
	pwm_gen_pkg::reg8_t dlo_d [NG];
	pwm_gen_pkg::reg8_t bhi_q [NG];
	pwm_gen_pkg::reg8_t bhi_d [NG];
	pwm_gen_pkg::reg8_t blo_q [NG];
	pwm_gen_pkg::reg8_t blo_d [NG];
	// Status and mask are three bits wide, one bit per generator.
	logic [2:0] irq_q;
	logic [2:0] irq_d;
	logic [2:0] mask_q;
	logic [2:0] mask_d;
	logic irq_out_d;
	logic ack_d;
	logic [31:0] rdat_d;
	logic [2:0] evt;

	logic access;
	logic write;
	logic [1:0] win;
	logic [2:0] idx;
	logic [2:0] clr;
	// The window index picks the generator; it only matters inside a window.
	int wg;

	always_comb begin
		wg = 0;
		access = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
		write = access & WB_WE_IN & WB_SEL_IN[0];
		win = WB_ADR_IN[6:5];
		idx = WB_ADR_IN[4:2];
		ctrl_d = ctrl_q;
		scl_d = scl_q;
		dhi_d = dhi_q;
		dlo_d = dlo_q;
		bhi_d = bhi_q;
		blo_d = blo_q;
		mask_d = mask_q;
		clr = 3'h0;
		rdat_d = 32'h0000_0000;
		// Every access is answered one cycle after it is taken; the held ack
		// masks the request in that cycle so a slow master is not served twice.
		ack_d = access;
		if (access && !WB_ADR_IN[7]) begin
			if (win == `PWM_GLOBAL_WINDOW) begin
				if (idx == `PWM_REG_IRQ_STATUS) begin
					rdat_d = {29'h0000_0000, irq_q};
					// RULE17 read or write-one clears
					if (!WB_WE_IN) begin
						clr = 3'h7;
					end else if (write) begin
						clr = WB_DAT_IN[2:0];
					end
				end else if (idx == `PWM_REG_IRQ_MASK) begin
					rdat_d = {29'h0000_0000, mask_q};
					if (write) begin
						mask_d = WB_DAT_IN[2:0];
					end
				end
			end else begin
				wg = int'(win);
				unique case (idx)
					`PWM_REG_CONTROL: begin
						rdat_d = word_of(ctrl_q[wg]);
						if (write) begin
							ctrl_d[wg] = WB_DAT_IN[7:0];
						end
					end
					`PWM_REG_SCALER: begin
						rdat_d = word_of(scl_q[wg]);
						if (write) begin
							scl_d[wg] = WB_DAT_IN[7:0];
						end
					end
					`PWM_REG_DUTY_HIGH: begin
						rdat_d = word_of(dhi_q[wg]);
						if (write) begin
							dhi_d[wg] = WB_DAT_IN[7:0];
						end
					end
					`PWM_REG_DUTY_LOW: begin
						rdat_d = word_of(dlo_q[wg]);
						if (write) begin
							dlo_d[wg] = WB_DAT_IN[7:0];
						end
					end
					`PWM_REG_BOUND_HIGH: begin
						rdat_d = word_of(bhi_q[wg]);
						if (write) begin
							bhi_d[wg] = WB_DAT_IN[7:0];
						end
					end
					`PWM_REG_BOUND_LOW: begin
						rdat_d = word_of(blo_q[wg]);
						if (write) begin
							blo_d[wg] = WB_DAT_IN[7:0];
						end
					end
					default: begin
						rdat_d = 32'h0000_0000;
					end
				endcase
			end
		end
		// A new event in the clearing cycle is kept: set beats clear.
		// A read clears every bit, so software must serve all pending
		// generators from the value that one read returns.
		irq_d = (irq_q & ~clr) | evt;
		// The interrupt line is computed from the next status, so it rises on
		// the same edge as the status bit that it reflects.
		irq_out_d = |(irq_d & mask_d);
	end

	// Read data stands only in the ack cycle and reads zero otherwise.
	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			for (int g = 0; g < NG; g++) begin
				ctrl_q[g] <= `PWM_REG_RESET;
				scl_q[g] <= `PWM_REG_RESET;
				dhi_q[g] <= `PWM_REG_RESET;
				dlo_q[g] <= `PWM_REG_RESET;
				bhi_q[g] <= `PWM_REG_RESET;
				blo_q[g] <= `PWM_REG_RESET;
			end
			irq_q <= 3'h0;
			mask_q <= 3'h0;
			IRQ_OUT <= 1'b0;
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			scl_q <= scl_d;
			dhi_q <= dhi_d;
			dlo_q <= dlo_d;
			bhi_q <= bhi_d;
			blo_q <= blo_d;
			irq_q <= irq_d;
			mask_q <= mask_d;
			IRQ_OUT <= irq_out_d;
			WB_ACK_OUT <= ack_d;
			WB_DAT_OUT <= rdat_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Generators. dc counts source ticks inside one counter step.
	// Each counter step lasts P*(K+1) source ticks. The counter runs from zero
	// up to the counter bound and wraps, so a period holds bound plus one steps.
	// The pin is high from the wrap until the duty step, and for part of the
	// duty step itself: half of it, or all of it when the half-step bit is set.
	// That extra half count is what gives the duty its eleventh bit.
	// The pins are registered, so every pin edge trails its counter state by
	// one clock; all generators share that lag, which keeps pairs aligned.

	pwm_gen_pkg::div_t dc_q [NG];
	pwm_gen_pkg::div_t dc_d [NG];
	pwm_gen_pkg::bound_t cnt_q [NG];
	pwm_gen_pkg::bound_t cnt_d [NG];
	logic [11:0] pin_d;
	logic [11:0] oe_d;

	pwm_gen_pkg::div_t div;
	pwm_gen_pkg::div_t hi_lim;
	pwm_gen_pkg::bound_t cb;
	pwm_gen_pkg::bound_t db;
	logic en;
	logic tick;
	logic high;
	logic level;

	// RULE1 same logic per generator
	always_comb begin
		div = 12'h001;
		hi_lim = 12'h000;
		cb = 10'h000;
		db = 10'h000;
		en = 1'b0;
		tick = 1'b0;
		high = 1'b0;
		level = 1'b0;
		evt = 3'h0;
		pin_d = 12'h000;
		oe_d = 12'h000;
		dc_d = dc_q;
		cnt_d = cnt_q;
		for (int g = 0; g < NG; g++) begin
			div = div_of(scl_q[g]);
			// RULE5 period bound
			cb = bound_of(bhi_q[g], blo_q[g]);
			// RULE6 duty bound upper bits
			db = bound_of(dhi_q[g], dlo_q[g]);
			// With an odd division the half step rounds down to a whole tick.
			// RULE10 half-step adds half a count
			hi_lim = dlo_q[g][`PWM_DUTY_HALF_BIT] ? div : (div >> 1);
			en = ctrl_q[g][`PWM_CTRL_ENABLE];
			// The fast RC tick is an enable pulse, so the counter stays in the
			// system clock domain and needs no crossing logic.
			// RULE2 clock source select
			tick = ctrl_q[g][`PWM_CTRL_FAST_RC] ? FAST_RC_TICK_IN : 1'b1;
			if (!en) begin
				// RULE19 disabled holds zero
				dc_d[g] = 12'h000;
				cnt_d[g] = 10'h000;
			end else if (tick) begin
				// RULE7 step every P*(K+1) ticks
				if (dc_q[g] >= div - 12'h001) begin
					dc_d[g] = 12'h000;
					// RULE18 wrap after bound
					if (cnt_q[g] >= cb) begin
						cnt_d[g] = 10'h000;
						evt[g] = ~scl_q[g][`PWM_SCL_IRQ_AT_DUTY];
					end else begin
						cnt_d[g] = cnt_q[g] + 10'h001;
					end
					// In duty mode the event marks the step onto the duty bound instead
					// of the wrap; a duty bound above the counter bound never fires.
					// RULE14 interrupt at duty match
					if (scl_q[g][`PWM_SCL_IRQ_AT_DUTY] && cnt_d[g] == db) begin
						evt[g] = 1'b1;
					end
				end else begin
					dc_d[g] = dc_q[g] + 12'h001;
				end
			end
			// RULE18 high from wrap through duty
			high = (cnt_q[g] < db) || (cnt_q[g] == db && dc_q[g] < hi_lim);
			// Gating acts on the level before inversion, so a gated pin with
			// inversion set rests high; the option is fixed per generator at build.
			// RULE11 build option
			// RULE12 comparator high forces off
			level = en & high & ~(GATE_BY_COMPARATOR[g] & COMP_RESULT_IN);
			// The output enable follows the generator enable and the pin select, so the pin is
			// driven whatever its port direction says. A select beyond the pins
			// that the generator owns drives nothing.
			for (int p = 0; p < PIN_SLOTS; p++) begin
				// RULE3 one pin by select
				// RULE4 enable overrides port direction
				// RULE13 invert applies to driven pin
				if (en && int'(ctrl_q[g][`PWM_CTRL_PIN_MSB:`PWM_CTRL_PIN_LSB]) == p
						&& p < int'(pins_of(g))) begin
					oe_d[g * PIN_SLOTS + p] = 1'b1;
					pin_d[g * PIN_SLOTS + p] = level ^ ctrl_q[g][`PWM_CTRL_INVERT];
				end
			end
		end
	end

	// A disabled generator already holds its counters at zero through the
	// next-state logic; reset only has to cover the first cycles.
	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			for (int g = 0; g < NG; g++) begin
				dc_q[g] <= 12'h000;
				cnt_q[g] <= 10'h000;
			end
			PWM_PIN_OUT <= 12'h000;
			PWM_PIN_OE_OUT <= 12'h000;
		end else begin
			dc_q <= dc_d;
			cnt_q <= cnt_d;
			PWM_PIN_OUT <= pin_d;
			PWM_PIN_OE_OUT <= oe_d;
		end
	end

endmodule
`default_nettype wire

/* File: pwm_gen_checker_assertions.sv */
// Purpose: Port assertions of the PWM block.
// Assumes: One bus request at a time.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module pwm_gen_checker (
	input wire logic CLOCK_IN,
	input wire logic SYS_RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	input wire logic IRQ_OUT,
	input wire logic [11:0] PWM_PIN_OUT,
	input wire logic [11:0] PWM_PIN_OE_OUT
);
	default clocking @(posedge CLOCK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	property p_ack; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
	a_pulse: assert property (p_pulse) else $error("long ack");
	property p_unmap; WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN[7] |-> WB_DAT_OUT == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_irq; WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h60 && $past(IRQ_OUT)
		|-> WB_DAT_OUT[2:0] != 3'h0; endproperty
	a_irq: assert property (p_irq) else $error("empty status");
	property p_one; $onehot0(PWM_PIN_OE_OUT[3:0]) && $onehot0(PWM_PIN_OE_OUT[7:4])
		&& $onehot0(PWM_PIN_OE_OUT[11:8]); endproperty
	a_one: assert property (p_one) else $error("two pins");
	property p_slot; !PWM_PIN_OE_OUT[3] && !PWM_PIN_OE_OUT[7]; endproperty
	a_slot: assert property (p_slot) else $error("no such pin");
	property p_rel; (PWM_PIN_OUT & ~PWM_PIN_OE_OUT) == 12'h0; endproperty
	a_rel: assert property (p_rel) else $error("released pin");
	property p_rst; disable iff (1'b0) SYS_RST_IN |=> PWM_PIN_OE_OUT == 12'h0 && !IRQ_OUT;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
endmodule
`default_nettype wire

/* File: pwm_load.sv */
// Purpose: Load on one pin; measures period and high time.
// Assumes: The pin is pulled low while released.
// Notes: Counts are clock cycles between rising edges.
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
	input wire logic clk_in,
	input wire logic out_in,
	input wire logic oe_in,
	output var int period_out,
	output var int high_out
);
	logic lvl;
	logic last = 1'b0;
	int n = 0;
	int h = 0;
	assign lvl = oe_in ? out_in : 1'b0;
	always @(posedge clk_in) begin
		last <= lvl;
		n <= (lvl && !last) ? 1 : n + 1;
		h <= (lvl && !last) ? 1 : h + int'(lvl);
		if (lvl && !last) begin
			period_out <= n;
			high_out <= h;
		end
	end
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench of the PWM block.
// Assumes: The load sits on pin 0 of the first generator.
// Notes: Random settings from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, rst = 1'b1, tick = 1'b0, comp = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, seen;
	logic [7:0] adr = 8'h00, r;
	logic [31:0] dat = 32'h0, rdat;
	logic [11:0] pout, poe;
	int per, hi, n_fail = 0, n_compared = 0;
	always #5 clk = ~clk;
	// A tick every second cycle keeps the slow-source timing exact to predict.
	always @(posedge clk) tick <= ~tick;
	pwm_gen_11bit #(.GATE_BY_COMPARATOR(3'h1)) pwm_gen_11bit_i (.CLOCK_IN(clk),
		.SYS_RST_IN(rst), .FAST_RC_TICK_IN(tick), .COMP_RESULT_IN(comp), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(dat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .IRQ_OUT(irq), .PWM_PIN_OUT(pout),
		.PWM_PIN_OE_OUT(poe));
	pwm_load pwm_load_i (.clk_in(clk), .out_in(pout[0]), .oe_in(poe[0]), .period_out(per),
		.high_out(hi));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		r = rdat[7:0];
		{cyc, stb} <= 2'b00;
	endtask
	function automatic int period_of(input int d, input int cb, input int src);
		return d * (cb + 1) * (src + 1);
	endfunction
	function automatic int high_of(input int d, input int db, input int h, input int src);
		return (db * d + (h ? d : d / 2)) * (src + 1);
	endfunction
	task automatic meas(input logic inv, input logic src);
		int cb, db, h, d, pe, he;
		logic [7:0] sc;
		cb = $urandom_range(7, 2);
		db = $urandom_range(cb - 1, 1);
		h = $urandom_range(1, 0);
		sc = 8'($urandom_range(2, 0) << 5 | $urandom_range(1, 0));
		d = (1 << 2 * sc[6:5]) * (sc[0] + 1);
		pe = period_of(d, cb, int'(src));
		he = high_of(d, db, h, int'(src));
		wb(1'b1, 8'h00, 8'h00);
		wb(1'b1, 8'h10, 8'(cb >> 2));
		wb(1'b1, 8'h14, 8'(cb << 6));
		wb(1'b1, 8'h08, 8'(db >> 2));
		wb(1'b1, 8'h0C, 8'(db << 6 | h << 5));
		wb(1'b1, 8'h04, sc);
		wb(1'b1, 8'h00, {1'b1, inv, 1'b0, src, 4'h0});
		repeat (1700) @(posedge clk);
		chk(per, pe);
		chk(hi, inv ? pe - he : he);
	endtask
	task automatic complete_run();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////
	initial begin
		logic [7:0] v, a;
		static logic [7:0] m [6] = '{8'hD3, 8'hFF, 8'hFF, 8'hE0, 8'hFF, 8'hC0};
		logic both, s0, s1;
		void'($urandom(32'hF6B4));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			a = 8'(i / 6 * 32 + i % 6 * 4);
			wb(1'b0, a, 8'h00);
			chk(r, 8'h00);
			v = 8'($urandom);
			wb(1'b1, a, v);
			wb(1'b0, a, 8'h00);
			chk(r & m[i % 6], v & m[i % 6]);
			wb(1'b1, a, 8'h00);
		end
		wb(1'b1, 8'h80, 8'hFF);
		wb(1'b0, 8'h80, 8'h00);
		chk(rdat, 32'h0);
		for (int i = 0; i < 12; i++) begin
			wb(1'b1, 8'(i / 4 * 32), 8'(8'h80 | i % 4));
			@(posedge clk);
			chk(poe[i / 4 * 4 +: 4], i % 4 < (i < 8 ? 3 : 4) ? 4'h1 << i % 4 : 4'h0);
		end
		for (int i = 0; i < 5; i++) begin
			meas(i[0], i[1]);
			wb(1'b1, 8'h00, 8'h00);
			@(posedge clk);
			chk(poe[3:0], 4'h0);
		end
		meas(1'b0, 1'b0);
		for (int j = 1; j >= 0; j--) begin
			comp <= j[0];
			repeat (3) @(posedge clk);
			seen = 1'b0;
			repeat (600) begin
				@(posedge clk);
				seen = seen | pout[0];
			end
			chk(seen, !j[0]);
		end
		wb(1'b1, 8'h00, 8'h00);
		wb(1'b1, 8'h20, 8'h00);
		for (int g = 0; g < 2; g++) begin
			wb(1'b1, 8'(g * 32 + 16), 8'h07);
			wb(1'b1, 8'(g * 32 + 20), 8'hC0);
			wb(1'b1, 8'(g * 32 + 8), g ? 8'h02 : 8'h04);
			wb(1'b1, 8'(g * 32 + 12), 8'h00);
			wb(1'b1, 8'(g * 32 + 4), 8'h00);
		end
		wb(1'b1, 8'h00, 8'hC0);
		wb(1'b1, 8'h20, 8'h80);
		{both, s0, s1} = 3'b000;
		repeat (300) begin
			@(posedge clk);
			both = both | (pout[0] & pout[4]);
			s0 = s0 | pout[0];
			s1 = s1 | pout[4];
		end
		chk(both, 1'b0);
		chk({s0, s1}, 2'b11);
		wb(1'b1, 8'h20, 8'h00);
		wb(1'b1, 8'h30, 8'h00);
		wb(1'b1, 8'h00, 8'h00);
		wb(1'b1, 8'h34, 8'h40);
		wb(1'b1, 8'h20, 8'h80);
		repeat (20) @(posedge clk);
		chk(irq, 1'b0);
		wb(1'b1, 8'h64, 8'h02);
		repeat (4) @(posedge clk);
		chk(irq, 1'b1);
		wb(1'b1, 8'h20, 8'h00);
		wb(1'b0, 8'h60, 8'h00);
		chk(r[1], 1'b1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wb(1'b1, 8'h24, 8'h80);
		wb(1'b1, 8'h20, 8'h80);
		repeat (20) @(posedge clk);
		chk(irq, 1'b0);
		wb(1'b1, 8'h28, 8'h00);
		repeat (10) @(posedge clk);
		chk(irq, 1'b1);
		complete_run();
	end
	initial begin
		#600000;
		n_fail++;
		complete_run();
	end
endmodule
bind pwm_gen_11bit pwm_gen_checker pwm_gen_checker_i (.CLOCK_IN, .SYS_RST_IN, .WB_CYC_IN,
	.WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_DAT_OUT, .WB_ACK_OUT, .IRQ_OUT, .PWM_PIN_OUT,
	.PWM_PIN_OE_OUT);
`default_nettype wire
